// *** core/phyci_regs.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "phyci_defs.svh"
// What this block does
// - Status bit 0 mirrors link-up; reading never clears it.
// - Sleep mode applies only while power save enable bit is set.
// - Mode field 00 normal, 01 reserved, 10 active, 11 passive sleep.
// - Active sleep keeps management and energy detect, pulses every 1.4 s.
// - Passive sleep keeps management and energy detect, no pulses.
// - FIFO bridges receive to transmit clock; software picks depth.
// - Collision shown in full duplex only when enabled; always in half.
// - Polarity bit 1 idles pin high and asserts low.
// - Test interrupt bit forces the interrupt while set.
// - Master enable gates all events; enable bits 7:4 serve both latched bits 15:12 and lower events 7:4.
// - Output enable makes shared pin an interrupt output, else power-down input.
// - Latched bit 15 flags link quality change while link up.
// - Latched bit 14 flags energy detect change.
// - Latched bit 13 flags link status change.
// - Latched bit 12 flags speed change.
// - Low bits of status one are per-event enables, reset 0.
module phyci_regs #(
	parameter int NLP_CYCLES = `PHYCI_NLP_CYCLES
) (
	input  wire logic        i_mclk,
	input  wire logic        i_rst,
	input  wire logic [4:0]  i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [15:0] o_rdata,
	input  wire logic        i_link_up,
	input  wire logic        i_full_duplex,
	input  wire logic        i_col_raw,
	input  wire logic        i_energy_detect,
	input  wire logic        i_ev_link_quality,
	input  wire logic        i_ev_energy,
	input  wire logic        i_ev_link_status,
	input  wire logic        i_ev_speed,
	input  wire logic [7:0]  i_ev_lower,
	input  wire logic        i_pd_pin_in,
	output logic             o_pin_out,
	output logic             o_pin_oe,
	output logic             o_powerdown,
	output logic             o_pll_disable,
	output logic             o_sleep_powered_down,
	output logic             o_nlp_pulse,
	output logic             o_scrambler_bypass,
	output logic [3:0]       o_fifo_nibbles,
	output logic             o_col,
	output logic [1:0]       o_mode_state
);
	logic [15:0]               ctrl;
	logic [3:0]                latched;
	logic [7:0]                lower_latched;
	logic [7:0]                ev_enable;
	phyci_pkg::phyci_pstate_t  pstate;
	phyci_pkg::phyci_pstate_t  next_pstate;
	logic                      nlp_tick;

	wire sel_sts  = (i_addr == `PHYCI_ADDR_PHY_STATUS);
	wire sel_ctrl = (i_addr == `PHYCI_ADDR_PHY_SPEC_CTRL);
	wire sel_irq  = (i_addr == `PHYCI_ADDR_IRQ_STATUS_ONE);
	wire wr_ctrl  = i_wr && sel_ctrl;
	wire wr_irq   = i_wr && sel_irq;
	wire rd_irq   = i_rd && sel_irq;

	wire       psave_en = ctrl[`PHYCI_BIT_PSAVE_EN];
	wire [1:0] mode     = ctrl[`PHYCI_BIT_MODE_HI:`PHYCI_BIT_MODE_LO];
	// Mode only counts while power save is enabled; code 01 behaves as normal
	wire       want_active  = psave_en && (mode == 2'b10);
	wire       want_passive = psave_en && (mode == 2'b11);

	wire [3:0] ev_hi = {i_ev_link_quality && i_link_up, i_ev_energy,
		i_ev_link_status, i_ev_speed};
	// Set wins over a clearing read in the same cycle
	wire [3:0] next_latched = (rd_irq ? 4'h0 : latched) | ev_hi;
	wire [7:0] next_lower   = (rd_irq ? 8'h0 : lower_latched) | i_ev_lower;

	wire [3:0] hi_enables = ev_enable[7:4];
	wire event_pending = (|(latched & hi_enables)) || (|(lower_latched & ev_enable));
	wire irq_active = ctrl[`PHYCI_BIT_IRQ_TEST]
		|| (ctrl[`PHYCI_BIT_IRQ_EN] && event_pending);
	wire next_pin = irq_active ^ ctrl[`PHYCI_BIT_IRQ_POL];

	// Bits 11:8 of status one belong to a neighbouring block and read 0 here
	wire [15:0] irq_word = {latched, 4'h0, ev_enable};
	wire [15:0] rd_mux = sel_sts  ? {15'h0, i_link_up} :
		sel_ctrl ? ctrl :
		sel_irq  ? irq_word : 16'h0;

	wire [1:0] fifo_code = ctrl[`PHYCI_BIT_FIFO_HI:`PHYCI_BIT_FIFO_LO];
	wire [3:0] next_nibbles = (fifo_code == 2'b11) ? 4'h8 : 4'h4 + {2'h0, fifo_code};
	wire next_col = i_col_raw && (!i_full_duplex || ctrl[`PHYCI_BIT_COL_FD]);

	always_comb begin
		next_pstate = pstate;
		unique case (pstate)
			phyci_pkg::PHYCI_NORMAL: begin
				if (want_active && !i_energy_detect)
					next_pstate = phyci_pkg::PHYCI_ACTIVE;
				else if (want_passive && !i_energy_detect)
					next_pstate = phyci_pkg::PHYCI_PASSIVE;
			end
			phyci_pkg::PHYCI_ACTIVE: begin
				if (i_energy_detect || !want_active)
					next_pstate = phyci_pkg::PHYCI_WAKE;
			end
			phyci_pkg::PHYCI_PASSIVE: begin
				if (i_energy_detect || !want_passive)
					next_pstate = phyci_pkg::PHYCI_WAKE;
			end
			phyci_pkg::PHYCI_WAKE: begin
				// Stay up while a partner is present so the link can form
				if (!i_energy_detect)
					next_pstate = phyci_pkg::PHYCI_NORMAL;
			end
			default: next_pstate = phyci_pkg::PHYCI_NORMAL;
		endcase
	end

	wire asleep = (pstate == phyci_pkg::PHYCI_ACTIVE) || (pstate == phyci_pkg::PHYCI_PASSIVE);
	wire [1:0] next_mode_state = (pstate == phyci_pkg::PHYCI_ACTIVE)  ? 2'b10 :
		(pstate == phyci_pkg::PHYCI_PASSIVE) ? 2'b11 : 2'b00;

	phyci_nlp_timer #(
		.PERIOD (NLP_CYCLES)
	) u_nlp (
		.i_mclk (i_mclk),
		.i_rst  (i_rst),
		.i_run  (pstate == phyci_pkg::PHYCI_ACTIVE),
		.o_tick (nlp_tick)
	);

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			ctrl          <= `PHYCI_CTRL_RESET;
			ev_enable     <= 8'h0;
			latched       <= 4'h0;
			lower_latched <= 8'h0;
			pstate        <= phyci_pkg::PHYCI_NORMAL;
		end else begin
			if (wr_ctrl)
				ctrl <= i_wdata & `PHYCI_CTRL_WMASK;
			if (wr_irq)
				ev_enable <= i_wdata[7:0];
			latched       <= next_latched;
			lower_latched <= next_lower;
			pstate        <= next_pstate;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata              <= 16'h0;
			o_pin_out            <= 1'b1;
			o_pin_oe             <= 1'b0;
			o_powerdown          <= 1'b0;
			o_pll_disable        <= 1'b0;
			o_sleep_powered_down <= 1'b0;
			o_nlp_pulse          <= 1'b0;
			o_scrambler_bypass   <= 1'b0;
			o_fifo_nibbles       <= 4'h5;
			o_col                <= 1'b0;
			o_mode_state         <= 2'b00;
		end else begin
			o_rdata              <= i_rd ? rd_mux : 16'h0;
			o_pin_out            <= next_pin;
			o_pin_oe             <= ctrl[`PHYCI_BIT_IRQ_OE];
			// Pin acts as active-low power-down input only when not driven
			o_powerdown          <= !ctrl[`PHYCI_BIT_IRQ_OE] && !i_pd_pin_in;
			o_pll_disable        <= ctrl[`PHYCI_BIT_PLL_DIS];
			o_sleep_powered_down <= asleep;
			// Gated so a pulse never outlives the sleep state shown beside it
			o_nlp_pulse          <= nlp_tick && (pstate == phyci_pkg::PHYCI_ACTIVE);
			o_scrambler_bypass   <= ctrl[`PHYCI_BIT_SCR_BYPASS];
			o_fifo_nibbles       <= next_nibbles;
			o_col                <= next_col;
			o_mode_state         <= next_mode_state;
		end
	end
endmodule // phyci_regs
`default_nettype wire

// *** shared/phyci_defs.svh ***
`ifndef PHYCI_DEFS_SVH
`define PHYCI_DEFS_SVH
`define PHYCI_ADDR_PHY_STATUS      5'h10
`define PHYCI_ADDR_PHY_SPEC_CTRL   5'h11
`define PHYCI_ADDR_IRQ_STATUS_ONE  5'h12
`define PHYCI_CTRL_RESET           16'h0108
`define PHYCI_CTRL_WMASK           16'hff1f
`define PHYCI_BIT_PLL_DIS          15
`define PHYCI_BIT_PSAVE_EN         14
`define PHYCI_BIT_MODE_HI          13
`define PHYCI_BIT_MODE_LO          12
`define PHYCI_BIT_SCR_BYPASS       11
`define PHYCI_BIT_FIFO_HI          9
`define PHYCI_BIT_FIFO_LO          8
`define PHYCI_BIT_COL_FD           4
`define PHYCI_BIT_IRQ_POL          3
`define PHYCI_BIT_IRQ_TEST         2
`define PHYCI_BIT_IRQ_EN           1
`define PHYCI_BIT_IRQ_OE           0
`define PHYCI_NLP_PERIOD_MS        1400
`define PHYCI_CLK_KHZ              10000
`define PHYCI_NLP_CYCLES           (`PHYCI_NLP_PERIOD_MS * `PHYCI_CLK_KHZ)
`endif

// *** shared/phyci_pkg.sv ***
package phyci_pkg;
	typedef enum logic [3:0] {
		PHYCI_NORMAL  = 4'h1,
		PHYCI_ACTIVE  = 4'h2,
		PHYCI_PASSIVE = 4'h4,
		PHYCI_WAKE    = 4'h8
	} phyci_pstate_t;
endpackage

// *** core/phyci_nlp_timer.sv ***
`timescale 1ns/10ps
`default_nettype none
// Period timer held at zero unless i_run is high; emits a one-cycle pulse when the count wraps
module phyci_nlp_timer #(
	parameter int PERIOD = 14000000
) (
	input  wire logic i_mclk,
	input  wire logic i_rst,
	input  wire logic i_run,
	output logic      o_tick
);
	logic [31:0] count;
	wire         wrap = (count == 32'(PERIOD - 1));
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			count  <= 32'h0;
			o_tick <= 1'b0;
		end else begin
			o_tick <= i_run && wrap;
			count  <= (!i_run || wrap) ? 32'h0 : count + 32'h1;
		end
	end
endmodule // phyci_nlp_timer
`default_nettype wire

// *** sim/phyci_regs_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
module phyci_regs_properties (
	input wire logic        i_mclk, i_rst, i_wr, i_rd, i_full_duplex, i_col_raw, i_link_up,
	input wire logic [4:0]  i_addr,
	input wire logic [15:0] i_wdata, o_rdata,
	input wire logic        o_pin_out, o_pin_oe, o_powerdown, o_nlp_pulse, o_col,
	input wire logic        o_sleep_powered_down,
	input wire logic [3:0]  o_fifo_nibbles,
	input wire logic [1:0]  o_mode_state
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
		else $error("read data not idle");
	a_link_mirror: assert property ($past(i_rd && i_addr == 5'h10) |->
		o_rdata == {15'h0, $past(i_link_up)}) else $error("link bit wrong");
	a_oe_follow: assert property (i_wr && i_addr == 5'h11 |->
		##2 o_pin_oe == $past(i_wdata[0], 2)) else $error("pin enable wrong");
	a_test_irq: assert property (i_wr && i_addr == 5'h11 && i_wdata[2] |->
		##2 o_pin_out == !$past(i_wdata[3], 2)) else $error("test interrupt level wrong");
	a_col_half: assert property (!i_full_duplex && i_col_raw |=> o_col)
		else $error("half duplex collision lost");
	a_fifo_code: assert property (o_fifo_nibbles inside {4'h4, 4'h5, 4'h6, 4'h8})
		else $error("fifo depth illegal");
	a_nlp_active: assert property (o_nlp_pulse |-> o_mode_state == 2'b10)
		else $error("pulse outside active sleep");
	a_nlp_single: assert property (o_nlp_pulse |=> !o_nlp_pulse)
		else $error("pulse too long");
	a_sleep_down: assert property (o_mode_state != 2'b00 |-> o_sleep_powered_down)
		else $error("sleep without power down");
	a_pd_output: assert property (o_pin_oe && $past(o_pin_oe) |-> !o_powerdown)
		else $error("power down while pin drives");
endmodule // phyci_regs_properties
`default_nettype wire

// *** sim/phyci_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Host drives power down only while the device leaves the pin alone
module phyci_host_model (
	input  wire logic i_out,
	input  wire logic i_oe,
	input  wire logic i_pd_n,
	output logic      o_pin
);
	assign o_pin = i_oe ? i_out : i_pd_n;
endmodule // phyci_host_model
`default_nettype wire

// *** sim/phyci_regs_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module phyci_regs_bench;
	logic        clk = 0, rst = 1, wr = 0, rd = 0, lk = 0, fd = 0, cr = 0, en = 1, pdn = 1, rdd = 0;
	logic [4:0]  a = '0;
	logic [15:0] wd = '0, x, n, rdo, eq[$], mq[$];
	logic [3:0]  ev = '0, v, fn, dep[4] = '{4'h4, 4'h5, 4'h6, 4'h8};
	logic [31:0] s = 32'h857c3c60;
	logic        po, oe, pd, pll, sp, nlp, sb, col, pin;
	logic [1:0]  ms;
	int          err_total = 0, checks = 0, tn = 0;
	phyci_regs #(.NLP_CYCLES(20)) phyci_regs_i (.i_mclk(clk), .i_rst(rst), .i_addr(a),
		.i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdo), .i_link_up(lk), .i_full_duplex(fd),
		.i_col_raw(cr), .i_energy_detect(en), .i_ev_link_quality(ev[3]), .i_ev_energy(ev[2]),
		.i_ev_link_status(ev[1]), .i_ev_speed(ev[0]), .i_ev_lower(8'h00), .i_pd_pin_in(pin),
		.o_pin_out(po), .o_pin_oe(oe), .o_powerdown(pd), .o_pll_disable(pll),
		.o_sleep_powered_down(sp), .o_nlp_pulse(nlp), .o_scrambler_bypass(sb),
		.o_fifo_nibbles(fn), .o_col(col), .o_mode_state(ms));
	phyci_host_model phyci_host_model_i (.i_out(po), .i_oe(oe), .i_pd_n(pdn), .o_pin(pin));
	initial begin
		forever #50 clk = ~clk;
	end
	function automatic logic [15:0] rnd();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s[15:0];
	endfunction
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic w(input logic [4:0] ad, input logic [15:0] d);
		wr <= 1'b1; a <= ad; wd <= d;
		@(posedge clk);
		wr <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	// Bits 11:8 of status one belong to a neighbouring block, so callers mask them
	task automatic r(input logic [4:0] ad, input logic [15:0] e, input logic [15:0] m);
		rd <= 1'b1; a <= ad; eq.push_back(e); mq.push_back(m);
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
	endtask
	task automatic nx();
		tn++;
		$display("test %0d done", tn);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk) rdd <= rd;
	always @(negedge clk) begin
		if (rdd) begin
			chk(rdo & mq[0], eq[0]);
			eq.delete(0);
			mq.delete(0);
		end
	end
	initial begin
		#(5000 * 100);
		err_total++;
		wrap_up();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		r(5'h11, 16'h0108, '1);
		r(5'h12, '0, '1);
		r(5'h05, '0, '1);
		w(5'h10, 16'hffff);
		lk <= 1'b1;
		repeat (2) r(5'h10, 16'h0001, '1);
		nx();
		x = rnd() & 16'hfbff;
		w(5'h11, x);
		r(5'h11, x & 16'hfb1f, '1);
		chk({sb, pll}, {x[11], x[15]});
		for (int i = 0; i < 4; i++) begin
			w(5'h11, {6'h00, 2'(i), 8'h08});
			chk(16'(fn), 16'(dep[i]));
		end
		nx();
		w(5'h11, 16'h000b);
		w(5'h12, '0);
		ev <= 4'hf;
		@(posedge clk);
		ev <= '0;
		repeat (2) @(posedge clk);
		chk(16'(pin), 16'h0001);
		r(5'h12, 16'hf000, 16'hf0ff);
		w(5'h12, 16'h00f0);
		repeat (3) begin
			v = 4'(rnd()) | 4'h1;
			ev <= v;
			@(posedge clk);
			ev <= '0;
			repeat (2) @(posedge clk);
			chk(16'(pin), '0);
			r(5'h12, {v, 12'h0f0}, 16'hf0ff);
			r(5'h12, 16'h00f0, 16'hf0ff);
		end
		chk(16'(pin), 16'h0001);
		nx();
		w(5'h11, 16'h0005);
		chk(16'(pin), 16'h0001);
		w(5'h11, 16'h0001);
		chk(16'(pin), '0);
		w(5'h11, '0);
		pdn <= 1'b0;
		repeat (3) @(posedge clk);
		chk(16'(pd), 16'h0001);
		pdn <= 1'b1;
		fd <= 1'b1;
		cr <= 1'b1;
		repeat (2) @(posedge clk);
		chk(16'(col), '0);
		w(5'h11, 16'h0010);
		chk(16'(col), 16'h0001);
		fd <= 1'b0;
		w(5'h11, '0);
		chk(16'(col), 16'h0001);
		cr <= 1'b0;
		nx();
		en <= 1'b0;
		w(5'h11, 16'h2000);
		repeat (4) @(posedge clk);
		chk(16'(ms), '0);
		for (int k = 0; k < 2; k++) begin
			w(5'h11, 16'h6000 | 16'(k << 12));
			n = '0;
			repeat (60) begin
				@(posedge clk);
				n += 16'(nlp);
			end
			chk(16'({k ? n == 0 : n > 1, ms, sp}), 16'(k ? 4'hf : 4'hd));
		end
		en <= 1'b1;
		repeat (6) @(posedge clk);
		chk(16'(ms), '0);
		nx();
		wrap_up();
	end
endmodule // phyci_regs_bench
bind phyci_regs phyci_regs_properties phyci_regs_properties_i (.i_mclk, .i_rst, .i_wr, .i_rd,
	.i_full_duplex, .i_col_raw, .i_link_up, .i_addr, .i_wdata, .o_rdata, .o_pin_out, .o_pin_oe,
	.o_powerdown, .o_nlp_pulse, .o_col, .o_sleep_powered_down, .o_fifo_nibbles, .o_mode_state);
`default_nettype wire
